// file: inc/irqpr_consts.vh
// constants for the interrupt level and extended mask register bank
// assumes an 8-bit special-function register address space
`ifndef IRQPR_CONSTS_VH
`define IRQPR_CONSTS_VH

// ==========================================================
// register addresses
`define IRQPR_ADDR_LEVEL 8'hB8
`define IRQPR_ADDR_XMASK 8'hE6
`define IRQPR_ADDR_XLEVEL 8'hF6

// ==========================================================
// reset values
`define IRQPR_LEVEL_RW_RST 7'h00
`define IRQPR_XMASK_RST 8'h00
`define IRQPR_XLEVEL_RST 8'h00
`define IRQPR_UNMAPPED_RD 8'h00

// ==========================================================
// base level register fields
`define IRQPR_LV_FIXED 7
`define IRQPR_LV_SPI 6
`define IRQPR_LV_TMR2 5
`define IRQPR_LV_UART 4
`define IRQPR_LV_TMR1 3
`define IRQPR_LV_EXT1 2
`define IRQPR_LV_TMR0 1
`define IRQPR_LV_EXT0 0

// ==========================================================
// extended mask and level register fields
`define IRQPR_XB_TMR3 7
`define IRQPR_XB_CMP1 6
`define IRQPR_XB_CMP0 5
`define IRQPR_XB_PCA 4
`define IRQPR_XB_CONV 3
`define IRQPR_XB_WIN 2
`define IRQPR_XB_RSVD 1
`define IRQPR_XB_TWI 0

// ==========================================================
// fixed source order, 0 ranks first
`define IRQPR_SRC_EXT0 0
`define IRQPR_SRC_TMR0 1
`define IRQPR_SRC_EXT1 2
`define IRQPR_SRC_TMR1 3
`define IRQPR_SRC_UART 4
`define IRQPR_SRC_TMR2 5
`define IRQPR_SRC_SPI 6
`define IRQPR_SRC_TWI 7
`define IRQPR_SRC_RSVD 8
`define IRQPR_SRC_WIN 9
`define IRQPR_SRC_CONV 10
`define IRQPR_SRC_PCA 11
`define IRQPR_SRC_CMP0 12
`define IRQPR_SRC_CMP1 13
`define IRQPR_SRC_TMR3 14
`define IRQPR_NUM_SRC 15
`define IRQPR_SRC_W 4

`endif

// file: design/irqpr_first_sel.v
// lowest-index-wins selector for one priority level
// assumes a plain request vector, combinational result
`timescale 1ns/100ps

module irqpr_first_sel
#(
    parameter N = 15,
    parameter W = 4
)
(
    input wire [N-1:0] req,
    output reg found,
    output reg [W-1:0] idx
);

    integer i;

    // ==========================================================
    // scan from the top so the lowest set index is kept last
    always @*
    begin
        found = 1'b0;
        idx = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                found = 1'b1;
                idx = i[W-1:0];
            end
        end
    end

endmodule // irqpr_first_sel

// file: design/irqpr_regs.v
// interrupt level register, extended mask and extended level registers
// with two-level arbitration toward the core's vectoring logic
// assumes the core pulses irq_take when it vectors, irq_ret on return
// Functional notes
// - top bit of base level register reads one, writes ignored
// - base level bit 6 picks serial peripheral interrupt level
// - base level bit 5 picks timer 2 interrupt level
// - base level bit 4 picks UART interrupt level
// - base level bit 3 picks timer 1 interrupt level
// - base level bit 2 picks external interrupt 1 level
// - base level bit 1 picks timer 0 interrupt level
// - base level bit 0 picks external interrupt 0 level
// - extended mask bit 7 passes either timer 3 overflow flag
// - extended mask bit 6 passes comparator 1 rise or fall flag
// - extended mask bit 5 passes comparator 0 rise or fall flag
// - extended mask bit 4 gates all counter array requests
// - extended mask bit 3 gates conversion-complete requests
// - extended mask bit 2 gates window-compare requests
// - extended mask bit 0 gates two-wire bus requests
// - extended level bit 7 picks timer 3 level
// - extended level bits 6 and 5 pick comparator 1 and 0 levels
// - extended level bit 4 picks counter array level
// - extended level bit 3 picks conversion-complete level
// - extended level bit 2 picks window-compare level
// - extended level bit 0 picks two-wire bus level
// - global gate low blocks every source regardless of masks
// - equal-level ties go by fixed order, 0 first, 14 last
`timescale 1ns/100ps
`include "irqpr_consts.vh"

module irqpr_regs
#(
    parameter NSRC = `IRQPR_NUM_SRC,
    parameter SW = `IRQPR_SRC_W
)
(
    input wire sys_clk,
    input wire rst_b,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_q,
    output reg sfr_hit_q,
    input wire global_irq_gate,
    input wire [6:0] base_irq_mask,
    input wire [6:0] base_irq_pend,
    input wire twowire_pend,
    input wire window_cmp_flag,
    input wire conv_done_flag,
    input wire counter_array_pend,
    input wire comparator_zero_rise_flag,
    input wire comparator_zero_fall_flag,
    input wire comparator_one_rise_flag,
    input wire comparator_one_fall_flag,
    input wire timer_three_low_overflow,
    input wire timer_three_high_overflow,
    input wire irq_take,
    input wire irq_ret,
    output reg irq_req_q,
    output reg [SW-1:0] irq_src_q,
    output reg irq_level_q,
    output reg insvc_hi_q,
    output reg insvc_lo_q
);

    // ==========================================================
    // reset release through two flip-flops
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_n_int;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n_int = rst_sync_q;

    // ==========================================================
    // register storage
    reg [6:0] level_q;
    reg [7:0] xmask_q;
    reg [7:0] xlevel_q;
    wire wr_level;
    wire wr_xmask;
    wire wr_xlevel;

    // address decode of the three registers
    assign wr_level = sfr_wr && (sfr_addr == `IRQPR_ADDR_LEVEL);
    assign wr_xmask = sfr_wr && (sfr_addr == `IRQPR_ADDR_XMASK);
    assign wr_xlevel = sfr_wr && (sfr_addr == `IRQPR_ADDR_XLEVEL);

    always @(posedge sys_clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            level_q <= `IRQPR_LEVEL_RW_RST;
            xmask_q <= `IRQPR_XMASK_RST;
            xlevel_q <= `IRQPR_XLEVEL_RST;
        end
        else
        begin
            if (wr_level)
                level_q <= sfr_wdata[6:0];
            if (wr_xmask)
                xmask_q <= sfr_wdata;
            if (wr_xlevel)
                xlevel_q <= sfr_wdata;
        end
    end

    // ==========================================================
    // read path, one cycle after the address
    reg [7:0] rdata_d;
    reg hit_d;

    always @*
    begin
        rdata_d = `IRQPR_UNMAPPED_RD;
        hit_d = 1'b0;
        case (sfr_addr)
            `IRQPR_ADDR_LEVEL:
            begin
                rdata_d = {1'b1, level_q};
                hit_d = 1'b1;
            end
            `IRQPR_ADDR_XMASK:
            begin
                rdata_d = xmask_q;
                hit_d = 1'b1;
            end
            `IRQPR_ADDR_XLEVEL:
            begin
                rdata_d = xlevel_q;
                hit_d = 1'b1;
            end
            default:
            begin
                rdata_d = `IRQPR_UNMAPPED_RD;
                hit_d = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            sfr_rdata_q <= 8'h00;
            sfr_hit_q <= 1'b0;
        end
        else
        begin
            sfr_rdata_q <= rdata_d;
            sfr_hit_q <= hit_d;
        end
    end

    // ==========================================================
    // per-source masked requests
    reg [NSRC-1:0] req_vec;
    reg [NSRC-1:0] lvl_vec;

    always @*
    begin
        req_vec = {NSRC{1'b0}};
        // base sources use the outside enable bits
        req_vec[`IRQPR_SRC_EXT0] = base_irq_pend[0] & base_irq_mask[0];
        req_vec[`IRQPR_SRC_TMR0] = base_irq_pend[1] & base_irq_mask[1];
        req_vec[`IRQPR_SRC_EXT1] = base_irq_pend[2] & base_irq_mask[2];
        req_vec[`IRQPR_SRC_TMR1] = base_irq_pend[3] & base_irq_mask[3];
        req_vec[`IRQPR_SRC_UART] = base_irq_pend[4] & base_irq_mask[4];
        req_vec[`IRQPR_SRC_TMR2] = base_irq_pend[5] & base_irq_mask[5];
        req_vec[`IRQPR_SRC_SPI] = base_irq_pend[6] & base_irq_mask[6];
        req_vec[`IRQPR_SRC_TWI] = twowire_pend & xmask_q[`IRQPR_XB_TWI];
        req_vec[`IRQPR_SRC_WIN] = window_cmp_flag
            & xmask_q[`IRQPR_XB_WIN];
        req_vec[`IRQPR_SRC_CONV] = conv_done_flag
            & xmask_q[`IRQPR_XB_CONV];
        req_vec[`IRQPR_SRC_PCA] = counter_array_pend
            & xmask_q[`IRQPR_XB_PCA];
        req_vec[`IRQPR_SRC_CMP0] = (comparator_zero_rise_flag
            | comparator_zero_fall_flag) & xmask_q[`IRQPR_XB_CMP0];
        req_vec[`IRQPR_SRC_CMP1] = (comparator_one_rise_flag
            | comparator_one_fall_flag) & xmask_q[`IRQPR_XB_CMP1];
        req_vec[`IRQPR_SRC_TMR3] = (timer_three_low_overflow
            | timer_three_high_overflow) & xmask_q[`IRQPR_XB_TMR3];
        if (!global_irq_gate)
            req_vec = {NSRC{1'b0}};
    end

    // ==========================================================
    // per-source level, one means high
    always @*
    begin
        lvl_vec = {NSRC{1'b0}};
        lvl_vec[`IRQPR_SRC_EXT0] = level_q[`IRQPR_LV_EXT0];
        lvl_vec[`IRQPR_SRC_TMR0] = level_q[`IRQPR_LV_TMR0];
        lvl_vec[`IRQPR_SRC_EXT1] = level_q[`IRQPR_LV_EXT1];
        lvl_vec[`IRQPR_SRC_TMR1] = level_q[`IRQPR_LV_TMR1];
        lvl_vec[`IRQPR_SRC_UART] = level_q[`IRQPR_LV_UART];
        lvl_vec[`IRQPR_SRC_TMR2] = level_q[`IRQPR_LV_TMR2];
        lvl_vec[`IRQPR_SRC_SPI] = level_q[`IRQPR_LV_SPI];
        lvl_vec[`IRQPR_SRC_TWI] = xlevel_q[`IRQPR_XB_TWI];
        lvl_vec[`IRQPR_SRC_WIN] = xlevel_q[`IRQPR_XB_WIN];
        lvl_vec[`IRQPR_SRC_CONV] = xlevel_q[`IRQPR_XB_CONV];
        lvl_vec[`IRQPR_SRC_PCA] = xlevel_q[`IRQPR_XB_PCA];
        lvl_vec[`IRQPR_SRC_CMP0] = xlevel_q[`IRQPR_XB_CMP0];
        lvl_vec[`IRQPR_SRC_CMP1] = xlevel_q[`IRQPR_XB_CMP1];
        lvl_vec[`IRQPR_SRC_TMR3] = xlevel_q[`IRQPR_XB_TMR3];
    end

    // ==========================================================
    // fixed-order pick within each level
    wire hi_found;
    wire lo_found;
    wire [SW-1:0] hi_idx;
    wire [SW-1:0] lo_idx;

    irqpr_first_sel
    #(
        .N(NSRC),
        .W(SW)
    )
    u_sel_hi
    (
        .req(req_vec & lvl_vec),
        .found(hi_found),
        .idx(hi_idx)
    );

    irqpr_first_sel
    #(
        .N(NSRC),
        .W(SW)
    )
    u_sel_lo
    (
        .req(req_vec & ~lvl_vec),
        .found(lo_found),
        .idx(lo_idx)
    );

    // ==========================================================
    // in-service tracking of both levels
    reg insvc_hi_d;
    reg insvc_lo_d;
    wire took;

    assign took = irq_take && irq_req_q;

    // return closes the higher active level; a take in the same cycle wins
    always @*
    begin
        insvc_hi_d = insvc_hi_q;
        insvc_lo_d = insvc_lo_q;
        if (irq_ret)
        begin
            if (insvc_hi_q)
                insvc_hi_d = 1'b0;
            else
                insvc_lo_d = 1'b0;
        end
        if (took)
        begin
            if (irq_level_q)
                insvc_hi_d = 1'b1;
            else
                insvc_lo_d = 1'b1;
        end
    end

    // ==========================================================
    // arbitration against the next in-service state
    reg req_d;
    reg [SW-1:0] src_d;
    reg level_d;

    // high preempts low, never the reverse
    always @*
    begin
        req_d = 1'b0;
        src_d = {SW{1'b0}};
        level_d = 1'b0;
        if (hi_found && !insvc_hi_d)
        begin
            req_d = 1'b1;
            src_d = hi_idx;
            level_d = 1'b1;
        end
        else if (lo_found && !insvc_hi_d && !insvc_lo_d)
        begin
            req_d = 1'b1;
            src_d = lo_idx;
            level_d = 1'b0;
        end
    end

    // new settings seen at next arbitration
    always @(posedge sys_clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            irq_req_q <= 1'b0;
            irq_src_q <= {SW{1'b0}};
            irq_level_q <= 1'b0;
            insvc_hi_q <= 1'b0;
            insvc_lo_q <= 1'b0;
        end
        else
        begin
            irq_req_q <= req_d;
            irq_src_q <= src_d;
            irq_level_q <= level_d;
            insvc_hi_q <= insvc_hi_d;
            insvc_lo_q <= insvc_lo_d;
        end
    end

endmodule // irqpr_regs

// file: tb/irqpr_monitor.sv
// assertion checker for the level and mask register bank
// assumes it is bound to irqpr_regs and sees only its ports
`timescale 1ns/100ps

module irqpr_monitor
#(
    parameter SW = 4
)
(
    input wire sys_clk,
    input wire rst_b,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata_q,
    input wire sfr_hit_q,
    input wire global_irq_gate,
    input wire twowire_pend,
    input wire timer_three_low_overflow,
    input wire timer_three_high_overflow,
    input wire irq_take,
    input wire irq_ret,
    input wire irq_req_q,
    input wire [SW-1:0] irq_src_q,
    input wire irq_level_q,
    input wire insvc_hi_q,
    input wire insvc_lo_q
);
reg [3:0] ok_q;
reg [7:0] bl_q, xm_q, xl_q;

// ==========================================================
// shadow registers, armed once the reset synchroniser settles
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        ok_q <= 4'h0;
        bl_q <= 8'h00;
        xm_q <= 8'h00;
        xl_q <= 8'h00;
    end
    else
    begin
        ok_q <= {ok_q[2:0], 1'h1};
        if (sfr_wr && sfr_addr == 8'hB8)
            bl_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 8'hE6)
            xm_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 8'hF6)
            xl_q <= sfr_wdata;
    end
end

default clocking cb @(posedge sys_clk);
endclocking
default disable iff (!ok_q[3]);

// ==========================================================
// properties
fixed_bit_a: assert property (
    $past(sfr_addr) == 8'hB8 |-> sfr_hit_q && sfr_rdata_q[7])
    else $error("level register top bit read as zero");
gate_block_a: assert property (
    !global_irq_gate |=> !irq_req_q)
    else $error("request while global gate low");
no_preempt_a: assert property (
    irq_req_q |-> !insvc_hi_q && (irq_level_q || !insvc_lo_q))
    else $error("request does not outrank routine in service");
take_high_a: assert property (
    irq_take && irq_req_q && irq_level_q |=> insvc_hi_q)
    else $error("high take did not mark service");
take_low_a: assert property (
    irq_take && irq_req_q && !irq_level_q |=> insvc_lo_q)
    else $error("low take did not mark service");
ret_close_a: assert property (
    irq_ret && !irq_take && insvc_hi_q
    |=> !insvc_hi_q && insvc_lo_q == $past(insvc_lo_q))
    else $error("return did not close high level");
mask_tmr3_a: assert property (
    irq_req_q && irq_src_q == 4'hE |-> $past(xm_q[7] && global_irq_gate
    && (timer_three_low_overflow || timer_three_high_overflow)))
    else $error("timer three request not allowed");
level_tmr3_a: assert property (
    irq_req_q && irq_src_q == 4'hE |-> irq_level_q == $past(xl_q[7]))
    else $error("timer three level wrong");
mask_twi_a: assert property (
    irq_req_q && irq_src_q == 4'h7 |-> $past(xm_q[0] && twowire_pend))
    else $error("two-wire request not allowed");
level_ext0_a: assert property (
    irq_req_q && irq_src_q == 4'h0 |-> irq_level_q == $past(bl_q[0]))
    else $error("external zero level wrong");

endmodule // irqpr_monitor

bind irqpr_regs irqpr_monitor #(.SW(SW)) mon_u (.*);

// file: tb/irqpr_core_model.sv
// core-side model of the vectoring sequencer
// assumes its inputs change just after the rising edge
`timescale 1ns/100ps

module irqpr_core_model
(
    input wire sys_clk,
    input wire rst_b,
    input wire vec_en,
    input wire [3:0] lat,
    input wire ret_go,
    input wire irq_req_q,
    output reg irq_take,
    output reg irq_ret
);
reg [3:0] cnt_q;

// ==========================================================
// vector after lat+1 cycles of a standing request; return on command
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        cnt_q <= 4'h0;
        irq_take <= 1'h0;
        irq_ret <= 1'h0;
    end
    else
    begin
        irq_take <= 1'h0;
        irq_ret <= ret_go;
        cnt_q <= 4'h0;
        if (vec_en && irq_req_q && !irq_take)
        begin
            if (cnt_q == lat)
                irq_take <= 1'h1;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end
end

endmodule // irqpr_core_model

// file: tb/irq_enable_priority_regs_test.sv
// self-checking bench for the level and mask register bank
// assumes the core model answers requests when enabled
`timescale 1ns/100ps

module irq_enable_priority_regs_test;
reg sys_clk, rst_b, sfr_wr, gate, alt, vec_en, ret_go;
reg [3:0] lat;
reg [7:0] addr, wdata;
reg [6:0] bmask;
reg [14:0] pend;
wire [7:0] rdata;
wire [3:0] src;
wire hit, take, ret, req, lvl, ihi, ilo;
integer n_fail, comparisons, i, j, k;

irqpr_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(addr),
    .sfr_wr(sfr_wr), .sfr_wdata(wdata), .sfr_rdata_q(rdata),
    .sfr_hit_q(hit), .global_irq_gate(gate), .base_irq_mask(bmask),
    .base_irq_pend(pend[6:0]), .twowire_pend(pend[7]),
    .window_cmp_flag(pend[9]), .conv_done_flag(pend[10]),
    .counter_array_pend(pend[11]),
    .comparator_zero_rise_flag(pend[12] & ~alt),
    .comparator_zero_fall_flag(pend[12] & alt),
    .comparator_one_rise_flag(pend[13] & ~alt),
    .comparator_one_fall_flag(pend[13] & alt),
    .timer_three_low_overflow(pend[14] & ~alt),
    .timer_three_high_overflow(pend[14] & alt),
    .irq_take(take), .irq_ret(ret), .irq_req_q(req), .irq_src_q(src),
    .irq_level_q(lvl), .insvc_hi_q(ihi), .insvc_lo_q(ilo));

irqpr_core_model core_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .vec_en(vec_en), .lat(lat), .ret_go(ret_go), .irq_req_q(req),
    .irq_take(take), .irq_ret(ret));

initial
begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
end

// ==========================================================
// bus and compare tasks
task wr(input [7:0] a, input [7:0] d);
begin
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge sys_clk);
    sfr_wr <= 1'h0;
end
endtask

task cmp_rd(input [7:0] a, input [7:0] e);
begin
    @(posedge sys_clk) addr <= a;
    @(posedge sys_clk) #1;
    comparisons = comparisons + 1;
    if (rdata !== e || hit !== (a == 8'hB8 || a == 8'hE6 || a == 8'hF6))
    begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t read %h gave %h", $time, a, rdata);
    end
end
endtask

task cmp_irq(input er, input [3:0] es, input el);
begin
    repeat (2) @(posedge sys_clk);
    #1;
    comparisons = comparisons + 1;
    if (req !== er || (er && {src, lvl} !== {es, el}))
    begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t request %b %h %b", $time, req, src, lvl);
    end
end
endtask

task cmp_svc(input eh, input el);
begin
    comparisons = comparisons + 1;
    if ({ihi, ilo} !== {eh, el})
    begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t service flags %b %b", $time, ihi, ilo);
    end
end
endtask

task wait_take;
begin
    k = 0;
    while (take !== 1'h1 && k < 40)
    begin
        @(posedge sys_clk) #1;
        k = k + 1;
    end
    if (take !== 1'h1)
    begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t core never vectored", $time);
        summarize;
    end
    @(posedge sys_clk) #1;
end
endtask

task ret_pulse;
begin
    @(posedge sys_clk) ret_go <= 1'h1;
    @(posedge sys_clk) ret_go <= 1'h0;
end
endtask

task summarize;
begin
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
end
endtask

// ==========================================================
// main sequence
initial
begin
    n_fail = 0;
    comparisons = 0;
    {rst_b, sfr_wr, gate, alt, vec_en, ret_go} = 6'h00;
    {addr, wdata, bmask, pend} = 38'h0;
    lat = 4'h3;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge sys_clk);
    cmp_rd(8'hB8, 8'h80);
    cmp_rd(8'hE6, 8'h00);
    cmp_rd(8'hF6, 8'h00);
    wr(8'hB8, 8'h00);
    cmp_rd(8'hB8, 8'h80);
    wr(8'hB8, 8'h7F);
    cmp_rd(8'hB8, 8'hFF);
    wr(8'hE6, 8'hFD);
    cmp_rd(8'hE6, 8'hFD);
    wr(8'hF6, 8'hA5);
    cmp_rd(8'hF6, 8'hA5);
    wr(8'h55, 8'hFF);
    cmp_rd(8'h55, 8'h00);
    gate <= 1'h1;
    bmask <= 7'h7F;
    @(posedge sys_clk) pend <= 15'h7EFF;
    for (i = 0; i < 15; i = i + 1)
        if (i != 8)
        begin
            wr(8'hB8, i < 7 ? 8'h01 << i : 8'h00);
            wr(8'hF6, i > 6 ? 8'h01 << (i - 7) : 8'h00);
            alt <= i[0];
            cmp_irq(1'h1, i[3:0], 1'h1);
        end
    wr(8'hB8, 8'h00);
    wr(8'hF6, 8'h00);
    cmp_irq(1'h1, 4'h0, 1'h0);
    for (i = 7; i < 15; i = i + 1)
        for (j = 0; j < 2 && i != 8; j = j + 1)
        begin
            @(posedge sys_clk) pend <= 15'h0001 << i;
            alt <= j[0];
            wr(8'hE6, 8'hFD & ~(8'h01 << (i - 7)));
            cmp_irq(1'h0, 4'h0, 1'h0);
            wr(8'hE6, 8'h01 << (i - 7));
            cmp_irq(1'h1, i[3:0], 1'h0);
        end
    @(posedge sys_clk) pend <= 15'h0001;
    bmask <= 7'h7E;
    cmp_irq(1'h0, 4'h0, 1'h0);
    pend <= 15'h7EFF;
    bmask <= 7'h7F;
    wr(8'hE6, 8'hFD);
    gate <= 1'h0;
    cmp_irq(1'h0, 4'h0, 1'h0);
    gate <= 1'h1;
    wr(8'hF6, 8'h80);
    @(posedge sys_clk) pend <= 15'h0001;
    vec_en <= 1'h1;
    wait_take;
    cmp_svc(1'h0, 1'h1);
    cmp_irq(1'h0, 4'h0, 1'h0);
    @(posedge sys_clk) pend <= 15'h4001;
    cmp_irq(1'h1, 4'hE, 1'h1);
    wait_take;
    cmp_svc(1'h1, 1'h1);
    @(posedge sys_clk) pend <= 15'h0001;
    cmp_irq(1'h0, 4'h0, 1'h0);
    vec_en <= 1'h0;
    ret_pulse;
    cmp_irq(1'h0, 4'h0, 1'h0);
    cmp_svc(1'h0, 1'h1);
    ret_pulse;
    cmp_irq(1'h1, 4'h0, 1'h0);
    cmp_svc(1'h0, 1'h0);
    summarize;
end

endmodule // irq_enable_priority_regs_test
